// File: cie_alu.sv
// result and condition codes for the data operations
`timescale 1ns/100ps
module cie_alu (
   // operation and operands
   input wire cie_pkg::cie_op_t i_op,
   input wire logic [7:0] i_opnd,
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_idx,
   // result and flags
   output logic [7:0] o_res,
   output logic o_n,
   output logic o_z,
   output logic o_c,
   output logic o_c_upd
);
   always_comb begin
      o_res = i_opnd;
      o_c = 1'b0;
      o_c_upd = 1'b0;
      case (i_op)
         cie_pkg::OP_ONES_COMPLEMENT: begin
            o_res = ~i_opnd;
            o_c = 1'b1;
            o_c_upd = 1'b1;
         end
         cie_pkg::OP_COMPARE_INDEX: begin
            o_res = i_idx - i_opnd;
            o_c = (~i_idx[7] & i_opnd[7]) | (i_opnd[7] & o_res[7]) | (o_res[7] & ~i_idx[7]);
            o_c_upd = 1'b1;
         end
         cie_pkg::OP_DECREMENT: o_res = i_opnd - 8'h01;
         cie_pkg::OP_INCREMENT: o_res = i_opnd + 8'h01;
         cie_pkg::OP_EXCLUSIVE_OR: o_res = i_acc ^ i_opnd;
         cie_pkg::OP_SHIFT_LEFT: begin
            o_res = {i_opnd[6:0], 1'b0};
            o_c = i_opnd[7];
            o_c_upd = 1'b1;
         end
         default: o_res = i_opnd;
      endcase
   end

   assign o_n = o_res[7];
   assign o_z = (o_res == 8'h00);
endmodule : cie_alu

// File: cie_core.sv
// instruction subset sequencer: fetch, address, execute, stack
//
// Functional notes
// - ones-complement opcodes 43,53,33,73,63 take 3,3,5,5,6 cycles.
// - compare-index computes index minus operand, sets flags, writes nothing back.
// - compare-index carry is the borrow from index, operand and result bit 7.
// - compare-index opcodes A3,B3,C3,F3,E3,D3 take 2,3,4,3,4,5 cycles.
// - decrement subtracts one from accumulator, index or memory; carry untouched.
// - decrement opcodes 4A,5A,3A,7A,6A take 3,3,5,5,6 cycles.
// - exclusive-or of accumulator and operand goes into accumulator, flags updated.
// - exclusive-or opcodes A8,B8,C8,F8,E8,D8 take 2,3,4,3,4,5 cycles.
// - increment adds one to accumulator, index or memory; carry untouched.
// - increment opcodes 4C,5C,3C,7C,6C take 3,3,5,5,6 cycles.
// - jump loads program counter with effective address; opcodes BC,CC,FC,EC,DC.
// - call pushes return low then high byte, decrementing stack each push.
// - unused high program counter bits stack as ones; stack points at next free.
// - call opcodes BD,CD,FD,ED,DD take 5,6,5,6,7 cycles; flags kept.
// - call return address is past the 1, 2 or 3 instruction bytes.
// - load accumulator copies operand and sets flags; opcodes A6..D6.
// - load index copies operand and sets flags; opcodes AE..DE.
// - shift left moves bits up, zero into bit 0, carry from bit 7.
// - shift-left opcodes 48,58,38,78,68 take 3,3,5,5,6 cycles.
// - ones-complement inverts every bit of its operand.
`timescale 1ns/100ps
module cie_core #(
   parameter int unsigned PC_W = 13,
   parameter logic [15:0] RESET_PC = 16'h0000
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // memory bus, read data combinational from o_addr
   input wire logic [7:0] i_rdata,
   output logic [15:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_we,
   output logic o_re,
   // cpu state
   output logic [7:0] o_acc,
   output logic [7:0] o_idx,
   output logic [4:0] o_flags,
   output logic [15:0] o_pc,
   output logic [7:0] o_sp,
   output logic o_fetch,
   output logic o_illegal
);
   if (PC_W < 9 || PC_W > 16) begin : g_bad_pc_w
      $error("PC_W must lie between 9 and 16");
   end

   // bits above the implemented counter, forced high when stacked
   localparam logic [15:0] PC_FILL = 16'hffff << PC_W;

   cie_pkg::cie_state_t state_q, state_d;
   logic [2:0] cyc_q, cyc_d;
   logic [PC_W-1:0] pc_q, pc_d;
   logic [7:0] ir_q, ir_d, hi_q, hi_d;
   logic [15:0] ea_q, ea_d, addr_q, addr_d;
   logic [7:0] acc_q, acc_d, idx_q, idx_d, sp_q, sp_d, wdata_q, wdata_d;
   logic [4:0] flags_q, flags_d;
   logic we_q, we_d, re_q, re_d, illegal_q, illegal_d;

   cie_dec_if dec_if ();

   // decode the opcode on the bus during fetch, the held one afterwards
   wire [7:0] opcode_w = (state_q == cie_pkg::ST_FETCH) ? i_rdata : ir_q;

   cie_decoder u_dec (
      .i_opcode(opcode_w),
      .dec(dec_if)
   );

   wire is_jump_w = (dec_if.op == cie_pkg::OP_JUMP);
   wire is_call_w = (dec_if.op == cie_pkg::OP_CALL_SUBROUTINE);
   wire is_flow_w = is_jump_w || is_call_w;
   wire is_inh_w = (dec_if.mode == cie_pkg::MODE_INH_A) || (dec_if.mode == cie_pkg::MODE_INH_X);
   wire last_w = (cyc_q == dec_if.cycles - 3'h1);
   wire [PC_W-1:0] pc_inc_w = pc_q + 1'b1;
   wire [15:0] pc_full_w = 16'(pc_d);
   wire [15:0] idx_ext_w = {8'h00, idx_q};

   // effective address from the operand byte now on the bus
   wire [15:0] ea_w = (dec_if.mode == cie_pkg::MODE_DIR) ? {cie_pkg::ZERO_PAGE, i_rdata}
      : (dec_if.mode == cie_pkg::MODE_EXT) ? {hi_q, i_rdata}
      : (dec_if.mode == cie_pkg::MODE_IX) ? idx_ext_w
      : (dec_if.mode == cie_pkg::MODE_INDEXED_BYTE_OFFSET) ? {8'h00, i_rdata} + idx_ext_w
      : {hi_q, i_rdata} + idx_ext_w;

   // data operations run on the register in exec, else on bus data
   wire [7:0] alu_opnd_w = (state_q != cie_pkg::ST_EXEC) ? i_rdata
      : (dec_if.mode == cie_pkg::MODE_INH_X) ? idx_q : acc_q;
   wire alu_do_w = !is_flow_w && dec_if.legal && ((state_q == cie_pkg::ST_READ)
      || (state_q == cie_pkg::ST_EXEC && is_inh_w)
      || (state_q == cie_pkg::ST_OPLO && dec_if.mode == cie_pkg::MODE_IMM));
   wire to_acc_w = (dec_if.op == cie_pkg::OP_LOAD_ACCUMULATOR) || (dec_if.op == cie_pkg::OP_EXCLUSIVE_OR)
      || (dec_if.rmw && dec_if.mode == cie_pkg::MODE_INH_A);
   wire to_idx_w = (dec_if.op == cie_pkg::OP_LOAD_INDEX) || (dec_if.rmw && dec_if.mode == cie_pkg::MODE_INH_X);
   wire [cie_pkg::CYC_W-1:0] unused_cyc_w = '0;
   wire cie_pkg::cie_state_t done_st_w = last_w ? cie_pkg::ST_FETCH : cie_pkg::ST_WAIT;

   logic [7:0] alu_res;
   logic alu_n, alu_z, alu_c, alu_c_upd;

   cie_alu u_alu (
      .i_op(dec_if.op),
      .i_opnd(alu_opnd_w),
      .i_acc(acc_q),
      .i_idx(idx_q),
      .o_res(alu_res),
      .o_n(alu_n),
      .o_z(alu_z),
      .o_c(alu_c),
      .o_c_upd(alu_c_upd)
   );

   always_comb begin
      state_d = state_q;
      cyc_d = cyc_q + 3'h1;
      pc_d = pc_q;
      ir_d = ir_q;
      hi_d = hi_q;
      ea_d = ea_q;
      acc_d = acc_q;
      idx_d = idx_q;
      flags_d = flags_q;
      sp_d = sp_q;
      wdata_d = wdata_q;
      illegal_d = 1'b0;
      unique case (state_q)
         cie_pkg::ST_FETCH: begin
            ir_d = i_rdata;
            pc_d = pc_inc_w;
            if (!dec_if.legal) begin
               illegal_d = 1'b1;
               state_d = cie_pkg::ST_FETCH;
            end else begin
               unique case (dec_if.mode)
                  cie_pkg::MODE_INH_A, cie_pkg::MODE_INH_X: state_d = cie_pkg::ST_EXEC;
                  cie_pkg::MODE_IMM, cie_pkg::MODE_DIR, cie_pkg::MODE_INDEXED_BYTE_OFFSET: state_d = cie_pkg::ST_OPLO;
                  cie_pkg::MODE_EXT, cie_pkg::MODE_INDEXED_WORD_OFFSET: state_d = cie_pkg::ST_OPHI;
                  cie_pkg::MODE_IX: begin
                     ea_d = ea_w;
                     state_d = is_call_w ? cie_pkg::ST_PUSHL : is_jump_w ? cie_pkg::ST_EXEC : cie_pkg::ST_READ;
                  end
               endcase
            end
         end
         cie_pkg::ST_OPHI: begin
            hi_d = i_rdata;
            pc_d = pc_inc_w;
            state_d = cie_pkg::ST_OPLO;
         end
         cie_pkg::ST_OPLO: begin
            pc_d = pc_inc_w;
            ea_d = ea_w;
            if (dec_if.mode == cie_pkg::MODE_IMM) begin
               state_d = done_st_w;
            end else if (is_jump_w) begin
               pc_d = ea_w[PC_W-1:0];
               state_d = done_st_w;
            end else begin
               state_d = is_call_w ? cie_pkg::ST_PUSHL : cie_pkg::ST_READ;
            end
         end
         cie_pkg::ST_READ: begin
            if (dec_if.rmw) begin
               wdata_d = alu_res;
               state_d = cie_pkg::ST_WRITE;
            end else begin
               state_d = done_st_w;
            end
         end
         cie_pkg::ST_WRITE: state_d = done_st_w;
         cie_pkg::ST_EXEC: begin
            if (is_jump_w) begin
               pc_d = ea_q[PC_W-1:0];
            end
            state_d = done_st_w;
         end
         cie_pkg::ST_PUSHL: begin
            sp_d = sp_q - 8'h01;
            state_d = cie_pkg::ST_PUSHH;
         end
         cie_pkg::ST_PUSHH: begin
            sp_d = sp_q - 8'h01;
            pc_d = ea_q[PC_W-1:0];
            state_d = done_st_w;
         end
         cie_pkg::ST_WAIT: begin
            if (last_w) begin
               state_d = cie_pkg::ST_FETCH;
            end
         end
      endcase
      if (alu_do_w) begin
         if (to_acc_w) begin
            acc_d = alu_res;
         end
         if (to_idx_w) begin
            idx_d = alu_res;
         end
         flags_d[cie_pkg::FLAG_N] = alu_n;
         flags_d[cie_pkg::FLAG_Z] = alu_z;
         if (alu_c_upd) begin
            flags_d[cie_pkg::FLAG_C] = alu_c;
         end
      end
      if (state_d == cie_pkg::ST_FETCH) begin
         cyc_d = unused_cyc_w;
      end
   end

   // bus cycle for the state about to run
   assign re_d = (state_d == cie_pkg::ST_FETCH) || (state_d == cie_pkg::ST_OPHI)
      || (state_d == cie_pkg::ST_OPLO) || (state_d == cie_pkg::ST_READ);
   assign we_d = (state_d == cie_pkg::ST_WRITE) || (state_d == cie_pkg::ST_PUSHL) || (state_d == cie_pkg::ST_PUSHH);
   assign addr_d = ((state_d == cie_pkg::ST_READ) || (state_d == cie_pkg::ST_WRITE)) ? ea_d
      : ((state_d == cie_pkg::ST_PUSHL) || (state_d == cie_pkg::ST_PUSHH)) ? {cie_pkg::ZERO_PAGE, sp_d}
      : (state_d == cie_pkg::ST_WAIT || state_d == cie_pkg::ST_EXEC) ? addr_q : pc_full_w;
   wire [7:0] push_w = (state_d == cie_pkg::ST_PUSHL) ? pc_full_w[7:0]
      : (pc_full_w[15:8] | PC_FILL[15:8]);
   wire [7:0] wdata_nx_w = ((state_d == cie_pkg::ST_PUSHL) || (state_d == cie_pkg::ST_PUSHH)) ? push_w : wdata_d;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= cie_pkg::ST_FETCH;
         cyc_q <= '0;
         pc_q <= RESET_PC[PC_W-1:0];
         ir_q <= cie_pkg::RST_REG;
         hi_q <= cie_pkg::RST_REG;
         ea_q <= '0;
         addr_q <= 16'(RESET_PC[PC_W-1:0]);
         acc_q <= cie_pkg::RST_REG;
         idx_q <= cie_pkg::RST_REG;
         sp_q <= cie_pkg::RST_SP;
         flags_q <= cie_pkg::RST_FLAGS;
         wdata_q <= cie_pkg::RST_REG;
         we_q <= 1'b0;
         re_q <= 1'b1;
         illegal_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cyc_q <= cyc_d;
         pc_q <= pc_d;
         ir_q <= ir_d;
         hi_q <= hi_d;
         ea_q <= ea_d;
         addr_q <= addr_d;
         acc_q <= acc_d;
         idx_q <= idx_d;
         sp_q <= sp_d;
         flags_q <= flags_d;
         wdata_q <= wdata_nx_w;
         we_q <= we_d;
         re_q <= re_d;
         illegal_q <= illegal_d;
      end
   end

   assign o_addr = addr_q;
   assign o_wdata = wdata_q;
   assign o_we = we_q;
   assign o_re = re_q;
   assign o_acc = acc_q;
   assign o_idx = idx_q;
   assign o_flags = flags_q;
   assign o_pc = 16'(pc_q);
   assign o_sp = sp_q;
   assign o_fetch = (state_q == cie_pkg::ST_FETCH);
   assign o_illegal = illegal_q;

   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   wire fetch_w = (state_q == cie_pkg::ST_FETCH);
   sequence s_push_low;
      state_q == cie_pkg::ST_PUSHL && o_we && o_addr == {cie_pkg::ZERO_PAGE, sp_q};
   endsequence
   sequence s_push_high;
      state_q == cie_pkg::ST_PUSHH && o_we && o_addr == {cie_pkg::ZERO_PAGE, sp_q}
         && (o_wdata & PC_FILL[15:8]) == PC_FILL[15:8];
   endsequence

   a_compl_offset_len: assert property (fetch_w && i_rdata == 8'h63 |=> (!fetch_w)[*5] ##1 fetch_w)
      else $error("indexed complement length wrong");
   a_compl_carry: assert property (fetch_w && i_rdata == 8'h43 |-> ##2 o_flags[cie_pkg::FLAG_C]
      && o_acc == ~$past(o_acc, 2))
      else $error("complement result or carry wrong");
   a_load_flags: assert property (fetch_w && i_rdata == 8'ha6 ##1 1'b1 |=> o_acc == $past(i_rdata)
      && o_flags[cie_pkg::FLAG_Z] == (o_acc == 8'h00) && o_flags[cie_pkg::FLAG_N] == o_acc[7])
      else $error("load accumulator flags wrong");
   a_cmpx_carry: assert property (fetch_w && i_rdata == 8'ha3 ##1 1'b1 |=>
      o_flags[cie_pkg::FLAG_C] == ($past(i_rdata) > o_idx) && $stable(o_acc) && $stable(o_idx))
      else $error("compare index carry wrong");
   a_decr_carry: assert property (fetch_w && i_rdata == 8'h4a |-> ##2 $stable(o_flags[cie_pkg::FLAG_C])
      && o_acc == $past(o_acc) - 8'h01)
      else $error("decrement touched carry");
   a_call_dir_len: assert property (fetch_w && i_rdata == 8'hbd |=> (!fetch_w)[*4] ##1 fetch_w)
      else $error("call length wrong");
   a_call_push: assert property (state_q == cie_pkg::ST_OPLO && is_call_w |=> s_push_low ##1 s_push_high
      ##1 o_sp == $past(o_sp, 2) - 8'h02)
      else $error("return address push wrong");
   a_jump_dir: assert property (fetch_w && i_rdata == 8'hbc ##1 1'b1 |=> fetch_w
      && o_pc == 16'($past(i_rdata)) && $stable(o_flags))
      else $error("jump target wrong");
   a_shl_carry: assert property (fetch_w && i_rdata == 8'h48 |-> ##2
      o_flags[cie_pkg::FLAG_C] == $past(o_acc[7]) && o_acc == {$past(o_acc[6:0]), 1'b0})
      else $error("shift left wrong");
endmodule : cie_core

// File: cie_dec_if.sv
// decoded instruction fields passed from decoder to sequencer
`timescale 1ns/100ps
interface cie_dec_if;
   cie_pkg::cie_op_t op;
   cie_pkg::cie_mode_t mode;
   logic [cie_pkg::CYC_W-1:0] cycles;
   logic legal;
   logic rmw;
   modport dec (output op, output mode, output cycles, output legal, output rmw);
   modport core (input op, input mode, input cycles, input legal, input rmw);
endinterface : cie_dec_if

// File: cie_decoder.sv
// opcode to operation, mode and cycle count
`timescale 1ns/100ps
module cie_decoder (
   // opcode in
   input wire logic [7:0] i_opcode,
   // decoded fields
   cie_dec_if.dec dec
);
   wire [3:0] hi_w = i_opcode[7:4];
   wire [3:0] lo_w = i_opcode[3:0];
   wire rmw_grp_w = (hi_w == cie_pkg::HI_RMW_DIR) || (hi_w == cie_pkg::HI_INH_A) || (hi_w == cie_pkg::HI_INH_X)
                    || (hi_w == cie_pkg::HI_RMW_IXB) || (hi_w == cie_pkg::HI_RMW_IX);
   wire reg_grp_w = (hi_w >= cie_pkg::HI_IMM);
   logic [cie_pkg::CYC_W-1:0] base_cyc;

   always_comb begin
      dec.mode = cie_pkg::MODE_INH_A;
      dec.op = cie_pkg::OP_NONE;
      case (hi_w)
         cie_pkg::HI_INH_X: dec.mode = cie_pkg::MODE_INH_X;
         cie_pkg::HI_RMW_DIR, cie_pkg::HI_DIR: dec.mode = cie_pkg::MODE_DIR;
         cie_pkg::HI_RMW_IX, cie_pkg::HI_IX: dec.mode = cie_pkg::MODE_IX;
         cie_pkg::HI_RMW_IXB, cie_pkg::HI_IXB: dec.mode = cie_pkg::MODE_INDEXED_BYTE_OFFSET;
         cie_pkg::HI_IMM: dec.mode = cie_pkg::MODE_IMM;
         cie_pkg::HI_EXT: dec.mode = cie_pkg::MODE_EXT;
         cie_pkg::HI_IXW: dec.mode = cie_pkg::MODE_INDEXED_WORD_OFFSET;
         default: dec.mode = cie_pkg::MODE_INH_A;
      endcase
      if (rmw_grp_w) begin
         case (lo_w)
            cie_pkg::LO_COMPL: dec.op = cie_pkg::OP_ONES_COMPLEMENT;
            cie_pkg::LO_DECR: dec.op = cie_pkg::OP_DECREMENT;
            cie_pkg::LO_INCR: dec.op = cie_pkg::OP_INCREMENT;
            cie_pkg::LO_SHL: dec.op = cie_pkg::OP_SHIFT_LEFT;
            default: dec.op = cie_pkg::OP_NONE;
         endcase
      end else if (reg_grp_w) begin
         case (lo_w)
            cie_pkg::LO_CMPX: dec.op = cie_pkg::OP_COMPARE_INDEX;
            cie_pkg::LO_XOR: dec.op = cie_pkg::OP_EXCLUSIVE_OR;
            cie_pkg::LO_LDACC: dec.op = cie_pkg::OP_LOAD_ACCUMULATOR;
            cie_pkg::LO_LDIDX: dec.op = cie_pkg::OP_LOAD_INDEX;
            // no immediate form of jump or call
            cie_pkg::LO_JUMP: dec.op = (hi_w == cie_pkg::HI_IMM) ? cie_pkg::OP_NONE : cie_pkg::OP_JUMP;
            cie_pkg::LO_CALL: dec.op = (hi_w == cie_pkg::HI_IMM) ? cie_pkg::OP_NONE
                                                                 : cie_pkg::OP_CALL_SUBROUTINE;
            default: dec.op = cie_pkg::OP_NONE;
         endcase
      end
   end

   always_comb begin
      case (dec.mode)
         cie_pkg::MODE_IMM: base_cyc = cie_pkg::CYC_IMM;
         cie_pkg::MODE_DIR: base_cyc = cie_pkg::CYC_DIR;
         cie_pkg::MODE_EXT: base_cyc = cie_pkg::CYC_EXT;
         cie_pkg::MODE_IX: base_cyc = cie_pkg::CYC_IX;
         cie_pkg::MODE_INDEXED_BYTE_OFFSET: base_cyc = cie_pkg::CYC_IXB;
         default: base_cyc = cie_pkg::CYC_IXW;
      endcase
   end

   assign dec.legal = (dec.op != cie_pkg::OP_NONE);
   assign dec.rmw = rmw_grp_w;
   assign dec.cycles = !dec.legal ? cie_pkg::CYC_ILLEGAL
      : rmw_grp_w ? ((dec.mode == cie_pkg::MODE_INH_A || dec.mode == cie_pkg::MODE_INH_X) ? cie_pkg::CYC_RMW_INH
                     : (dec.mode == cie_pkg::MODE_INDEXED_BYTE_OFFSET) ? cie_pkg::CYC_RMW_IXB
                     : cie_pkg::CYC_RMW_MEM)
      : (dec.op == cie_pkg::OP_JUMP) ? base_cyc - cie_pkg::CYC_JUMP_LESS
      : (dec.op == cie_pkg::OP_CALL_SUBROUTINE) ? base_cyc + cie_pkg::CYC_CALL_MORE
      : base_cyc;
endmodule : cie_decoder

// File: cie_mem.sv
// combinational program and data memory model for the core bench
`timescale 1ns/100ps
module cie_mem (
   // clock
   input wire logic i_clk,
   // bus from core
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_we,
   // read data
   output logic [7:0] o_rdata
);
   logic [7:0] ram [0:65535];
   // read answers in the same cycle as the address
   assign o_rdata = ram[i_addr];
   always @(posedge i_clk) begin
      if (i_we) begin
         ram[i_addr] <= i_wdata;
      end
   end
endmodule : cie_mem

// File: cie_pkg.sv
// constants, types and opcode layout for the instruction subset core
package cie_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned CYC_W = 3;

   // addressing modes
   typedef enum logic [2:0] {
      MODE_INH_A, MODE_INH_X, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX,
      MODE_INDEXED_BYTE_OFFSET, MODE_INDEXED_WORD_OFFSET
   } cie_mode_t;

   // operations
   typedef enum logic [3:0] {
      OP_NONE, OP_ONES_COMPLEMENT, OP_COMPARE_INDEX, OP_DECREMENT, OP_EXCLUSIVE_OR, OP_INCREMENT,
      OP_JUMP, OP_CALL_SUBROUTINE, OP_LOAD_ACCUMULATOR, OP_LOAD_INDEX, OP_SHIFT_LEFT
   } cie_op_t;

   // sequencer states
   typedef enum logic [8:0] {
      ST_FETCH = 9'h001, ST_OPHI = 9'h002, ST_OPLO = 9'h004, ST_READ = 9'h008, ST_WRITE = 9'h010,
      ST_EXEC = 9'h020, ST_PUSHL = 9'h040, ST_PUSHH = 9'h080, ST_WAIT = 9'h100
   } cie_state_t;

   // opcode high nibble: addressing mode
   localparam logic [3:0] HI_RMW_DIR = 4'h3;
   localparam logic [3:0] HI_INH_A = 4'h4;
   localparam logic [3:0] HI_INH_X = 4'h5;
   localparam logic [3:0] HI_RMW_IXB = 4'h6;
   localparam logic [3:0] HI_RMW_IX = 4'h7;
   localparam logic [3:0] HI_IMM = 4'ha;
   localparam logic [3:0] HI_DIR = 4'hb;
   localparam logic [3:0] HI_EXT = 4'hc;
   localparam logic [3:0] HI_IXW = 4'hd;
   localparam logic [3:0] HI_IXB = 4'he;
   localparam logic [3:0] HI_IX = 4'hf;
   // opcode low nibble: operation
   localparam logic [3:0] LO_COMPL = 4'h3;
   localparam logic [3:0] LO_SHL = 4'h8;
   localparam logic [3:0] LO_DECR = 4'ha;
   localparam logic [3:0] LO_INCR = 4'hc;
   localparam logic [3:0] LO_CMPX = 4'h3;
   localparam logic [3:0] LO_LDACC = 4'h6;
   localparam logic [3:0] LO_XOR = 4'h8;
   localparam logic [3:0] LO_JUMP = 4'hc;
   localparam logic [3:0] LO_CALL = 4'hd;
   localparam logic [3:0] LO_LDIDX = 4'he;

   // cycle counts
   localparam logic [CYC_W-1:0] CYC_ILLEGAL = 3'h1;
   localparam logic [CYC_W-1:0] CYC_RMW_INH = 3'h3;
   localparam logic [CYC_W-1:0] CYC_RMW_MEM = 3'h5;
   localparam logic [CYC_W-1:0] CYC_RMW_IXB = 3'h6;
   localparam logic [CYC_W-1:0] CYC_IMM = 3'h2;
   localparam logic [CYC_W-1:0] CYC_DIR = 3'h3;
   localparam logic [CYC_W-1:0] CYC_EXT = 3'h4;
   localparam logic [CYC_W-1:0] CYC_IX = 3'h3;
   localparam logic [CYC_W-1:0] CYC_IXB = 3'h4;
   localparam logic [CYC_W-1:0] CYC_IXW = 3'h5;
   localparam logic [CYC_W-1:0] CYC_JUMP_LESS = 3'h1;
   localparam logic [CYC_W-1:0] CYC_CALL_MORE = 3'h2;

   // condition code layout and reset values
   localparam int unsigned FLAG_W = 5;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_C = 0;
   localparam logic [4:0] RST_FLAGS = 5'h08;
   localparam logic [7:0] RST_SP = 8'hff;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] ZERO_PAGE = 8'h00;
endpackage : cie_pkg

// File: tb_top.sv
// instruction subset bench: one program, checked instruction by instruction
`timescale 1ns/100ps
module tb_top;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [7:0] rdata, wdata, acc, idx, sp;
   logic [15:0] addr, pc;
   logic we, fetch, re, illegal;
   logic [4:0] flags;
   int bad_count = 0;
   int samples_checked = 0;
   logic [7:0] prog [0:14] = '{8'ha6, 8'h80, 8'h43, 8'ha8, 8'h7f, 8'h4a, 8'h48, 8'hae, 8'h10,
      8'ha3, 8'h20, 8'h5c, 8'h3a, 8'h40, 8'hbd};
   always #25 i_clk = ~i_clk;
   cie_core dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
      .o_we(we), .o_re(re), .o_acc(acc), .o_idx(idx), .o_flags(flags), .o_pc(pc), .o_sp(sp), .o_fetch(fetch),
      .o_illegal(illegal));
   cie_mem mem (.i_clk(i_clk), .i_addr(addr), .i_wdata(wdata), .i_we(we), .o_rdata(rdata));
   task automatic wrap_up();
      $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // run one instruction to the next fetch, then judge count and state
   task automatic step(input int cyc, input logic [7:0] ea, input logic [7:0] ex, input logic [4:0] ec);
      int n;
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
      end while (fetch !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         wrap_up();
      end else begin
         check(16'(n), 16'(cyc));
         check({8'h00, acc}, {8'h00, ea});
         check({8'h00, idx}, {8'h00, ex});
         check({11'h000, flags}, {11'h000, ec});
         check({14'h0000, re, illegal}, 16'h0002);
         check(addr, pc);
      end
   endtask : step
   task automatic t_accumulator_ops();
      step(2, 8'h80, 8'h00, 5'h0c);
      step(3, 8'h7f, 8'h00, 5'h09);
      step(2, 8'h00, 8'h00, 5'h0b);
      step(3, 8'hff, 8'h00, 5'h0d);
      step(3, 8'hfe, 8'h00, 5'h0d);
   endtask : t_accumulator_ops
   task automatic t_index_ops();
      step(2, 8'hfe, 8'h10, 5'h09);
      step(2, 8'hfe, 8'h10, 5'h0d);
      step(3, 8'hfe, 8'h11, 5'h09);
   endtask : t_index_ops
   task automatic t_memory_rmw();
      step(5, 8'hfe, 8'h11, 5'h0b);
      check({8'h00, mem.ram[16'h0040]}, 16'h0000);
   endtask : t_memory_rmw
   task automatic t_call_jump();
      step(5, 8'hfe, 8'h11, 5'h0b);
      check(pc, 16'h0030);
      check({8'h00, sp}, 16'h00fd);
      check({mem.ram[16'h00fe], mem.ram[16'h00ff]}, 16'he010);
      step(3, 8'hfe, 8'h11, 5'h0b);
      check(pc, 16'h0100);
      step(6, 8'hfe, 8'h11, 5'h0d);
      check({8'h00, mem.ram[16'h0012]}, 16'h0080);
      step(6, 8'hfe, 8'h11, 5'h09);
      check({8'h00, mem.ram[16'h0011]}, 16'h0062);
      step(2, 8'hfe, 8'h11, 5'h09);
      check(pc, 16'h0050);
   endtask : t_call_jump
   // opcode outside the subset at the jump target: one-cycle skip
   task automatic t_illegal_skip();
      @(posedge i_clk);
      #1;
      check({14'h0000, fetch, illegal}, 16'h0003);
      check(pc, 16'h0051);
   endtask : t_illegal_skip
   initial begin
      for (int a = 0; a < 65536; a++) begin
         mem.ram[a] = 8'h9d;
      end
      for (int a = 0; a < 15; a++) begin
         mem.ram[a] = prog[a];
      end
      mem.ram[16'h000f] = 8'h30;
      mem.ram[16'h0030] = 8'hcc;
      mem.ram[16'h0031] = 8'h01;
      mem.ram[16'h0032] = 8'h00;
      mem.ram[16'h0100] = 8'h6c;
      mem.ram[16'h0101] = 8'h01;
      mem.ram[16'h0040] = 8'h01;
      mem.ram[16'h0012] = 8'h7f;
      mem.ram[16'h0102] = 8'h63;
      mem.ram[16'h0103] = 8'h00;
      mem.ram[16'h0104] = 8'hbc;
      mem.ram[16'h0105] = 8'h50;
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'b1;
      #1;
      t_accumulator_ops();
      t_index_ops();
      t_memory_rmw();
      t_call_jump();
      t_illegal_skip();
      wrap_up();
   end
endmodule : tb_top
